// File: rtc_pkg.sv
package rtc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFFS_ACCESS_ENABLE = 8'h04;
  localparam logic [7:0] OFFS_FREQ_COMP = 8'h08;
  localparam logic [7:0] OFFS_TIME_LOAD = 8'h0C;
  localparam logic [7:0] OFFS_CAL_LOAD = 8'h10;
  localparam logic [7:0] OFFS_HOUR_FORMAT = 8'h14;

  // Reset values
  localparam logic [31:0] RST_FREQ_COMP = 32'h0000_0700;
  localparam logic [31:0] RST_TIME_LOAD = 32'h0000_0000;
  localparam logic [31:0] RST_CAL_LOAD = 32'h0005_0101;
  localparam logic RST_HOUR_24 = 1'b1;

  // Writable bit masks; reserved bits read as zero
  localparam logic [31:0] MASK_FREQ_COMP = 32'h0000_0F3F;
  localparam logic [31:0] MASK_TIME_LOAD = 32'h003F_7F7F;
  localparam logic [31:0] MASK_CAL_LOAD = 32'h00FF_1F3F;

  // Field positions
  localparam int FC_INT_LSB = 8;
  localparam int FC_INT_W = 4;
  localparam int FC_FRAC_LSB = 0;
  localparam int FC_FRAC_W = 6;
  localparam int HOUR_FMT_BIT = 0;
  localparam int ENF_BIT = 16;

  // Access enable password and hold time in RTC clocks
  localparam logic [15:0] ACCESS_PASSWORD = 16'hA965;
  localparam int ENF_HOLD_RTC_CLKS = 512;

  // Second length: base count plus integer field, fraction in sixtieths
  localparam logic [15:0] INT_BASE_HZ = 16'h7FF9;
  localparam logic [6:0] FRAC_DIV = 7'h3C;

  // Clocking
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RTC_HZ = 32768;
  localparam longint PS_PER_S = 64'd1_000_000_000_000;
  localparam int RTC_DIV_CYCLES = int'(PS_PER_S / (longint'(RTC_HZ) * CLK_PERIOD_PS));

  // BCD constants
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] HOUR_24_LAST = 8'h23;
  localparam logic [7:0] HOUR_AM11 = 8'h11;
  localparam logic [7:0] HOUR_AM12 = 8'h12;
  localparam logic [7:0] HOUR_PM12 = 8'h32;
  localparam logic [7:0] HOUR_PM01 = 8'h21;
  localparam logic [7:0] HOUR_PM11 = 8'h31;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // BCD time word, same layout as the time load register after masking
  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } time_s;

  // BCD date word, same layout as the calendar load register after masking
  typedef struct packed {
    logic [7:0] unused;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
  } cal_s;

  typedef enum logic [1:0] {
    W_COLLECT = 2'b00,
    W_COMMIT = 2'b01,
    W_RESP = 2'b11
  } wr_state_e;

  typedef enum logic {
    R_IDLE = 1'b0,
    R_DATA = 1'b1
  } rd_state_e;

endpackage

// File: rtc_time_counter.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_time_counter
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Settings
  input wire logic rtc_tick,
  input wire logic [FC_INT_W-1:0] comp_int,
  input wire logic [FC_FRAC_W-1:0] comp_frac,
  input wire logic hour_24,
  // Loads
  input wire logic time_load_en,
  input wire time_s time_load_val,
  input wire logic cal_load_en,
  input wire cal_s cal_load_val,
  // Live values
  output time_s time_now,
  output cal_s cal_now
);

  // Plain BCD step with wrap from last to first
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last, input logic [7:0] first);
    if (v == last) bcd_step = first;
    else if (v[3:0] == BCD_NINE) bcd_step = {v[7:4] + 4'h1, 4'h0};
    else bcd_step = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Hour step in either encoding; odd loaded values just count on
  function automatic logic [7:0] hour_step(input logic [7:0] v, input logic h24);
    if (h24) hour_step = bcd_step(v, HOUR_24_LAST, BCD_ZERO);
    else if (v == HOUR_AM11) hour_step = HOUR_PM12;
    else if (v == HOUR_PM11) hour_step = HOUR_AM12;
    else if (v == HOUR_AM12) hour_step = BCD_ONE;
    else if (v == HOUR_PM12) hour_step = HOUR_PM01;
    else hour_step = bcd_step(v, BCD_99, BCD_ZERO);
  endfunction

  logic [15:0] sub_cnt;
  logic [6:0] frac_acc;
  logic extra_clk;
  wire logic [15:0] sec_len = INT_BASE_HZ + 16'(comp_int) + 16'(extra_clk);
  wire logic sec_end = rtc_tick && (sub_cnt >= sec_len - 16'h1);
  wire logic [6:0] frac_sum = frac_acc + 7'(comp_frac);
  wire logic frac_carry = frac_sum >= FRAC_DIV;
  wire logic min_end = sec_end && time_now.second == BCD_59;
  wire logic hour_end = min_end && time_now.minute == BCD_59;
  wire logic last_hour = hour_24 ? (time_now.hour == HOUR_24_LAST) : (time_now.hour == HOUR_PM11);
  wire logic day_end = hour_end && last_hour;
  wire logic month_end = day_end && cal_now.day == BCD_31;
  wire logic year_end = month_end && cal_now.month == BCD_12;

  // Second length follows the trim fields, fraction spread over seconds
  always_ff @(posedge clk_sys) begin
    if (rst || time_load_en) begin
      sub_cnt <= 16'h0;
    end else if (sec_end) begin
      sub_cnt <= 16'h0;
    end else if (rtc_tick) begin
      sub_cnt <= sub_cnt + 16'h1;
    end
  end

  // Fraction accumulator adds one RTC clock to a second every time it reaches sixty
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frac_acc <= 7'h0;
      extra_clk <= 1'b0;
    end else if (sec_end) begin
      frac_acc <= frac_carry ? frac_sum - FRAC_DIV : frac_sum;
      extra_clk <= frac_carry;
    end
  end

  // Time of day; loaded digits taken as they are, no range
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      time_now <= time_s'(RST_TIME_LOAD);
    end else if (time_load_en) begin
      time_now <= time_load_val;
    end else begin
      if (sec_end) time_now.second <= bcd_step(time_now.second, BCD_59, BCD_ZERO);
      if (min_end) time_now.minute <= bcd_step(time_now.minute, BCD_59, BCD_ZERO);
      if (hour_end) time_now.hour <= hour_step(time_now.hour, hour_24);
    end
  end

  // Calendar; day wraps at 31 without month lengths, loads unchecked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_now <= cal_s'(RST_CAL_LOAD);
    end else if (cal_load_en) begin
      cal_now <= cal_load_val;
    end else begin
      if (day_end) cal_now.day <= bcd_step(cal_now.day, BCD_31, BCD_ONE);
      if (month_end) cal_now.month <= bcd_step(cal_now.month, BCD_12, BCD_ONE);
      if (year_end) cal_now.year <= bcd_step(cal_now.year, BCD_99, BCD_ZERO);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_pm_wrap;
    (hour_end && !hour_24 && !time_load_en && time_now.hour == HOUR_PM11) |=> time_now.hour == HOUR_AM12;
  endproperty
  a_pm_wrap: assert property (p_pm_wrap) else $error("11 PM did not wrap to 12 AM");

  property p_noon;
    (hour_end && !hour_24 && !time_load_en && time_now.hour == HOUR_AM11) |=> time_now.hour == HOUR_PM12;
  endproperty
  a_noon: assert property (p_noon) else $error("11 AM did not step to 32");

  property p_sec_len;
    sec_end |=> sub_cnt == 16'h0 && $stable(time_now.second) == 1'b0 || $past(time_load_en);
  endproperty
  a_sec_len: assert property (p_sec_len) else $error("Second end did not advance seconds");

endmodule
`default_nettype wire

// File: rtc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_regs
  import rtc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int RTC_DIV = RTC_DIV_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [ADDR_W-1:0] s_awaddr,
  // AXI4-Lite write data
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  // AXI4-Lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // AXI4-Lite read address
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [ADDR_W-1:0] s_araddr,
  // AXI4-Lite read data
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp
);

  // Byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      lane_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Word offset of a bus address
  function automatic logic [7:0] word_offs(input logic [ADDR_W-1:0] a);
    word_offs = {a[7:2], 2'b00};
  endfunction

  localparam int DIV_W = $clog2(RTC_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RTC_DIV - 1);
  localparam logic [9:0] ENF_LAST = 10'(ENF_HOLD_RTC_CLKS - 1);

  wr_state_e wstate;
  rd_state_e rstate;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [31:0] freq_comp;
  logic hour_24;
  logic access_enable_flag;
  logic [9:0] enf_age;
  logic [DIV_W-1:0] div_cnt;
  logic rtc_tick;
  time_s time_now;
  cal_s cal_now;

  // Handshake terms
  wire logic aw_take = s_awvalid && s_awready;
  wire logic w_take = s_wvalid && s_wready;
  wire logic ar_take = s_arvalid && s_arready;
  wire logic commit = wstate == W_COMMIT;
  wire logic [7:0] wr_offs = word_offs(waddr);
  wire logic [7:0] rd_offs = word_offs(s_araddr);

  // Write decode; gated registers ignore writes while access is closed
  wire logic hit_aer = wr_offs == OFFS_ACCESS_ENABLE;
  wire logic hit_fc = wr_offs == OFFS_FREQ_COMP;
  wire logic hit_tl = wr_offs == OFFS_TIME_LOAD;
  wire logic hit_cl = wr_offs == OFFS_CAL_LOAD;
  wire logic hit_hf = wr_offs == OFFS_HOUR_FORMAT;
  wire logic wr_mapped = hit_aer || hit_fc || hit_tl || hit_cl || hit_hf;
  wire logic [31:0] aer_word = lane_merge(32'h0, wdata, wstrb);
  wire logic pwd_ok = aer_word[15:0] == ACCESS_PASSWORD;
  wire logic [31:0] fc_word = lane_merge(freq_comp, wdata, wstrb) & MASK_FREQ_COMP;
  wire logic [31:0] tl_word = lane_merge(32'(time_now), wdata, wstrb) & MASK_TIME_LOAD;
  wire logic [31:0] cl_word = lane_merge(32'(cal_now), wdata, wstrb) & MASK_CAL_LOAD;
  wire logic [31:0] hf_word = lane_merge(32'(hour_24), wdata, wstrb);
  wire logic time_load_en = commit && hit_tl && access_enable_flag;
  wire logic cal_load_en = commit && hit_cl && access_enable_flag;

  // Read decode; live counters read back as the load registers
  wire logic rd_mapped = rd_offs == OFFS_ACCESS_ENABLE || rd_offs == OFFS_FREQ_COMP || rd_offs == OFFS_TIME_LOAD
                         || rd_offs == OFFS_CAL_LOAD || rd_offs == OFFS_HOUR_FORMAT;
  wire logic [31:0] rd_word =
    (rd_offs == OFFS_ACCESS_ENABLE) ? (32'(access_enable_flag) << ENF_BIT) :
    (rd_offs == OFFS_FREQ_COMP) ? (access_enable_flag ? freq_comp : 32'h0) :
    (rd_offs == OFFS_TIME_LOAD) ? 32'(time_now) :
    (rd_offs == OFFS_CAL_LOAD) ? 32'(cal_now) :
    (rd_offs == OFFS_HOUR_FORMAT) ? (32'(hour_24) << HOUR_FMT_BIT) : 32'h0;

  // Write sequencing: collect address and data in either order, commit, respond
  wire logic aw_have = aw_held || aw_take;
  wire logic w_have = w_held || w_take;
  wr_state_e next_wstate;
  always_comb begin
    case (wstate)
      W_COLLECT: next_wstate = (aw_have && w_have) ? W_COMMIT : W_COLLECT;
      W_COMMIT: next_wstate = W_RESP;
      W_RESP: next_wstate = s_bready ? W_COLLECT : W_RESP;
      default: next_wstate = W_COLLECT;
    endcase
  end

  // Write channel flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wstate <= W_COLLECT;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      wstate <= next_wstate;
      aw_held <= (next_wstate == W_COLLECT && wstate == W_RESP) ? 1'b0 : aw_have;
      w_held <= (next_wstate == W_COLLECT && wstate == W_RESP) ? 1'b0 : w_have;
      s_awready <= next_wstate == W_COLLECT && !(aw_have && wstate == W_COLLECT);
      s_wready <= next_wstate == W_COLLECT && !(w_have && wstate == W_COLLECT);
    end
  end

  // Captured write payload
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      waddr <= '0;
      wdata <= 32'h0;
      wstrb <= 4'h0;
    end else begin
      if (aw_take) waddr <= s_awaddr;
      if (w_take) wdata <= s_wdata;
      if (w_take) wstrb <= s_wstrb;
    end
  end

  // Write response; unmapped offsets answer with an error
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (commit) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bvalid && s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Read channel: one outstanding read, data latched when the address is taken
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rstate <= R_IDLE;
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= RESP_OKAY;
    end else begin
      case (rstate)
        R_IDLE: begin
          s_arready <= !ar_take;
          if (ar_take) begin
            rstate <= R_DATA;
            s_rvalid <= 1'b1;
            s_rdata <= rd_word;
            s_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
          end
        end
        R_DATA: begin
          if (s_rready) begin
            rstate <= R_IDLE;
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
          end
        end
        default: rstate <= R_IDLE;
      endcase
    end
  end

  // RTC clock stand-in derived from the system clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_cnt <= '0;
      rtc_tick <= 1'b0;
    end else begin
      div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + DIV_W'(1);
      rtc_tick <= div_cnt == DIV_LAST;
    end
  end

  // Access window: password opens it, any other value or the timeout closes it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      access_enable_flag <= 1'b0;
      enf_age <= 10'h0;
    end else if (commit && hit_aer) begin
      access_enable_flag <= pwd_ok;
      enf_age <= 10'h0;
    end else if (access_enable_flag && rtc_tick) begin
      access_enable_flag <= enf_age != ENF_LAST;
      enf_age <= enf_age + 10'h1;
    end
  end

  // Software registers; trim fields are taken as written
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_comp <= RST_FREQ_COMP;
      hour_24 <= RST_HOUR_24;
    end else if (commit) begin
      if (hit_fc && access_enable_flag) freq_comp <= fc_word;
      if (hit_hf) hour_24 <= hf_word[HOUR_FMT_BIT];
    end
  end

  // Counters; digits sit in the register layout so the masked word maps straight on
  rtc_time_counter u_counter (
    .clk_sys(clk_sys),
    .rst(rst),
    .rtc_tick(rtc_tick),
    .comp_int(freq_comp[FC_INT_LSB +: FC_INT_W]),
    .comp_frac(freq_comp[FC_FRAC_LSB +: FC_FRAC_W]),
    .hour_24(hour_24),
    .time_load_en(time_load_en),
    .time_load_val(time_s'(tl_word)),
    .cal_load_en(cal_load_en),
    .cal_load_val(cal_s'(cl_word)),
    .time_now(time_now),
    .cal_now(cal_now)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_fc_read_gated;
    (ar_take && rd_offs == OFFS_FREQ_COMP && !access_enable_flag) |=> s_rvalid && s_rdata == 32'h0;
  endproperty
  a_fc_read_gated: assert property (p_fc_read_gated) else $error("Compensation read leaked while closed");

  property p_fc_read_open;
    (ar_take && rd_offs == OFFS_FREQ_COMP && access_enable_flag) |=> s_rdata == $past(freq_comp);
  endproperty
  a_fc_read_open: assert property (p_fc_read_open) else $error("Compensation read wrong while open");

  property p_pwd_opens;
    (commit && hit_aer && pwd_ok) |=> access_enable_flag && enf_age == 10'h0;
  endproperty
  a_pwd_opens: assert property (p_pwd_opens) else $error("Password did not open access");

  property p_bad_pwd_closes;
    (commit && hit_aer && !pwd_ok) |=> !access_enable_flag;
  endproperty
  a_bad_pwd_closes: assert property (p_bad_pwd_closes) else $error("Wrong password left access open");

  property p_enf_timeout;
    (access_enable_flag && rtc_tick && enf_age == ENF_LAST && !(commit && hit_aer)) |=> !access_enable_flag;
  endproperty
  a_enf_timeout: assert property (p_enf_timeout) else $error("Access did not close after 512 clocks");

  property p_time_load;
    time_load_en |=> 32'(time_now) == $past(tl_word);
  endproperty
  a_time_load: assert property (p_time_load) else $error("Time load digits not taken as written");

  property p_cal_load;
    cal_load_en |=> 32'(cal_now) == $past(cl_word);
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("Calendar load digits not taken as written");

  property p_hour_fmt;
    (commit && hit_hf) |=> hour_24 == $past(hf_word[HOUR_FMT_BIT]);
  endproperty
  a_hour_fmt: assert property (p_hour_fmt) else $error("Hour format bit not stored");

  property p_after_reset;
    $fell(rst) |-> hour_24 && 32'(cal_now) == RST_CAL_LOAD && freq_comp == RST_FREQ_COMP;
  endproperty
  a_after_reset: assert property (@(posedge clk_sys) p_after_reset) else $error("Reset values wrong");

  // Hours may only move by counting, which needs minute and second at 59
  property p_closed_no_load;
    (commit && hit_tl && !access_enable_flag) |=> $stable(time_now.hour)
      || ($past(time_now.minute) == BCD_59 && $past(time_now.second) == BCD_59);
  endproperty
  a_closed_no_load: assert property (p_closed_no_load) else $error("Time loaded while access closed");

endmodule
`default_nettype wire

// File: rtc_time_calendar_load_and_trim_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_time_calendar_load_and_trim_bench
  import rtc_pkg::*;
;
  localparam logic [7:0] OFFS_UNMAPPED = 8'h40;
  localparam int WAIT_LIMIT = 200;

  // Clock and reset
  logic clk_sys;
  logic rst;
  // Register bus
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd_val;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, rd_resp;
  int err_count = 0;
  int n_tests = 0;

  // Divider shortened to 1 so two whole seconds fit the run
  rtc_regs #(.ADDR_W(8), .RTC_DIV(1)) dut_u (
    .clk_sys(clk_sys), .rst(rst),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp)
  );

  // Clock generator
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  // Verdict and end of run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: both channels offered at once, ready sampled mid-cycle since it only moves on edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_ok, w_ok, b_ok;
    logic [1:0] resp;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < WAIT_LIMIT; n++) begin
      @(negedge clk_sys);
      aw_ok = s_awvalid && s_awready;
      w_ok = s_wvalid && s_wready;
      b_ok = s_bvalid && s_bready;
      resp = s_bresp;
      @(posedge clk_sys);
      if (aw_ok) s_awvalid <= 1'b0;
      if (w_ok) s_wvalid <= 1'b0;
      if (b_ok) begin
        s_bready <= 1'b0;
        break;
      end
    end
    if (n == WAIT_LIMIT) begin
      err_count++;
      finish_test();
    end
    check("write_resp", {30'h0, resp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    logic ar_ok, r_ok;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < WAIT_LIMIT; n++) begin
      @(negedge clk_sys);
      ar_ok = s_arvalid && s_arready;
      r_ok = s_rvalid && s_rready;
      rd_val = s_rdata;
      rd_resp = s_rresp;
      @(posedge clk_sys);
      if (ar_ok) s_arvalid <= 1'b0;
      if (r_ok) begin
        s_rready <= 1'b0;
        break;
      end
    end
    if (n == WAIT_LIMIT) begin
      err_count++;
      finish_test();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string nm);
    rd(a);
    check(nm, rd_val, exp);
    check("read_resp", {30'h0, rd_resp}, {30'h0, er});
  endtask

  // Main sequence
  initial begin : main_seq
    int k;
    rst = 1'b1;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'hF;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset state, locked access
    rd_chk(OFFS_ACCESS_ENABLE, 32'h0000_0000, RESP_OKAY, "flag_reset");
    rd_chk(OFFS_FREQ_COMP, 32'h0000_0000, RESP_OKAY, "comp_locked");
    rd_chk(OFFS_CAL_LOAD, 32'h0005_0101, RESP_OKAY, "cal_reset");
    rd_chk(OFFS_HOUR_FORMAT, 32'h0000_0001, RESP_OKAY, "fmt_reset");
    wr(OFFS_TIME_LOAD, 32'h0012_3456, RESP_OKAY);
    rd_chk(OFFS_TIME_LOAD, 32'h0000_0000, RESP_OKAY, "time_locked");
    // Password opens access; reserved bits drop, digits taken unchecked
    wr(OFFS_ACCESS_ENABLE, 32'h0000_A965, RESP_OKAY);
    rd_chk(OFFS_ACCESS_ENABLE, 32'h0001_0000, RESP_OKAY, "flag_open");
    rd_chk(OFFS_FREQ_COMP, 32'h0000_0700, RESP_OKAY, "comp_reset");
    wr(OFFS_FREQ_COMP, 32'hFFFF_FFFF, RESP_OKAY);
    rd_chk(OFFS_FREQ_COMP, 32'h0000_0F3F, RESP_OKAY, "comp_fields");
    wr(OFFS_TIME_LOAD, 32'hFFFF_FFFF, RESP_OKAY);
    rd_chk(OFFS_TIME_LOAD, 32'h003F_7F7F, RESP_OKAY, "time_fields");
    wr(OFFS_CAL_LOAD, 32'hFFFF_FFFF, RESP_OKAY);
    rd_chk(OFFS_CAL_LOAD, 32'h00FF_1F3F, RESP_OKAY, "cal_fields");
    wr(OFFS_CAL_LOAD, 32'h0099_1231, RESP_OKAY);
    rd_chk(OFFS_CAL_LOAD, 32'h0099_1231, RESP_OKAY, "cal_digits");
    wr(OFFS_HOUR_FORMAT, 32'hFFFF_FFFE, RESP_OKAY);
    rd_chk(OFFS_HOUR_FORMAT, 32'h0000_0000, RESP_OKAY, "fmt_12h");
    wr(OFFS_HOUR_FORMAT, 32'h0000_0001, RESP_OKAY);
    rd_chk(OFFS_HOUR_FORMAT, 32'h0000_0001, RESP_OKAY, "fmt_24h");
    // Any other password value closes access at once
    wr(OFFS_ACCESS_ENABLE, 32'h0000_1234, RESP_OKAY);
    rd_chk(OFFS_ACCESS_ENABLE, 32'h0000_0000, RESP_OKAY, "flag_closed");
    rd_chk(OFFS_FREQ_COMP, 32'h0000_0000, RESP_OKAY, "comp_hidden");
    // Unmapped offset answers with an error and zero data
    wr(OFFS_UNMAPPED, 32'hFFFF_FFFF, RESP_SLVERR);
    rd_chk(OFFS_UNMAPPED, 32'h0000_0000, RESP_SLVERR, "unmapped");
    // Window lasts 512 RTC clocks, one system cycle each here
    wr(OFFS_ACCESS_ENABLE, 32'h0000_A965, RESP_OKAY);
    repeat (400) @(posedge clk_sys);
    rd_chk(OFFS_ACCESS_ENABLE, 32'h0001_0000, RESP_OKAY, "flag_held");
    repeat (150) @(posedge clk_sys);
    rd_chk(OFFS_ACCESS_ENABLE, 32'h0000_0000, RESP_OKAY, "flag_expired");
    // One second in 12-hour mode, shortest trim: 11:59:59 AM becomes noon
    wr(OFFS_ACCESS_ENABLE, 32'h0000_A965, RESP_OKAY);
    wr(OFFS_FREQ_COMP, 32'h0000_0000, RESP_OKAY);
    wr(OFFS_HOUR_FORMAT, 32'h0000_0000, RESP_OKAY);
    wr(OFFS_TIME_LOAD, 32'h0011_5959, RESP_OKAY);
    repeat (32500) @(posedge clk_sys);
    rd_chk(OFFS_TIME_LOAD, 32'h0011_5959, RESP_OKAY, "before_tick");
    for (k = 0; k < 400; k++) begin
      rd(OFFS_TIME_LOAD);
      if (rd_val !== 32'h0011_5959) break;
    end
    check("noon_12h", rd_val, 32'h0032_0000);
    // 11:59:59 PM ends the day; the loaded last day of year 99 rolls the whole date over
    wr(OFFS_ACCESS_ENABLE, 32'h0000_A965, RESP_OKAY);
    wr(OFFS_TIME_LOAD, 32'h0031_5959, RESP_OKAY);
    repeat (32500) @(posedge clk_sys);
    rd_chk(OFFS_TIME_LOAD, 32'h0031_5959, RESP_OKAY, "before_midnight");
    for (k = 0; k < 400; k++) begin
      rd(OFFS_TIME_LOAD);
      if (rd_val !== 32'h0031_5959) break;
    end
    check("midnight_12h", rd_val, 32'h0012_0000);
    rd_chk(OFFS_CAL_LOAD, 32'h0000_0101, RESP_OKAY, "date_rollover");
    finish_test();
  end
endmodule
`default_nettype wire
